// *** hdl/pwm_chan_regs.sv ***
// PWM channel: register file, reload arming, offset-trigger slave control.
// Assumes sibling channels deliver reload triggers and offset matches as
// one-cycle pulses on CORE_CLK_I; their mirror bits arrive as plain levels.
//
// Contract
// - Load trigger select: 11 channel 3, 10 channel 2, 01 channel 1, 00 reserved.
// - Load-armed flag clears itself after a buffer reload.
// - Software writing zero to load-armed cancels the pending reload.
// - The code naming this channel itself is reserved in both selectors.
// - Offset mode 00 runs independently, ignoring offset triggers.
// - Offset mode 01 starts on the trigger, then runs free.
// - Offset mode 10 makes one synchronised run per trigger.
// - Offset mode 11 runs continuously, resetting the counter on each trigger.
// - In centre mode, match point bit picks down-count match; else ignored.
// - Offset trigger select: 11 channel 3, 10 channel 2, 01 channel 1, 00 reserved.
// - Enable mirror bits 2..0 read and write each channel's enable.
// - Load mirror bits 2..0 reflect and arm each channel's load flag.
// - Output mirror bits 2..0 show each channel's output state.
// - Phase value held as high and low bytes, both read/write.
// - Duty value held as high and low bytes, both read/write.
// - Period value held as high and low bytes, both read/write.
// - Offset high byte is read/write.
// - Written values reach active buffers only at period boundary when armed.
// - With load-on-trigger, the sibling trigger starts reload at next boundary.
// - Mode field code 11 selects centre-aligned counting.
// - Match flags set on rising edge of each match signal.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module pwm_chan_regs
	import pwm_regs_pkg::*;
#(
	parameter logic [1:0] CHAN_ID = 2'h1
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	// AXI4-Lite write address and data
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	// AXI4-Lite read
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	// Sibling channel links, indexed by channel number 1..3
	input wire logic [3:1] RELOAD_TRIGGER_I,
	input wire logic [3:1] OFFSET_MATCH_SIG_I,
	input wire logic [3:1] SIB_ENABLE_I,
	input wire logic [3:1] SIB_ARMED_I,
	input wire logic [3:1] SIB_OUTPUT_I,
	output logic [3:1] SIB_ENABLE_WR_O,
	output logic [3:1] SIB_ENABLE_VAL_O,
	output logic [3:1] SIB_ARMED_WR_O,
	output logic [3:1] SIB_ARMED_VAL_O,
	// Counter core interface
	input wire logic PERIOD_BOUNDARY_I,
	input wire logic OUTPUT_STATE_I,
	input wire logic COUNT_UP_I,
	input wire logic OFFSET_EQ_I,
	input wire logic [3:0] MATCH_I,
	// Control to counter core
	output logic ENABLE_O,
	output logic [1:0] MODE_O,
	output logic RELOAD_O,
	output logic COUNTER_RESET_O,
	output logic RUN_O,
	output logic OFFSET_MATCH_SIG_O,
	output logic [15:0] PHASE_VALUE_O,
	output logic [15:0] DUTY_VALUE_O,
	output logic [15:0] PERIOD_VALUE_O,
	output logic [15:0] OFFSET_VALUE_O
);

	// Map a two-bit selector onto a sibling bit; own code and 00 give none
	function automatic logic pick_src(input logic [1:0] sel, input logic [3:1] v);
		logic r;
		r = 1'b0;
		if (sel != SEL_RESERVED && sel != CHAN_ID) begin
			r = v[sel];
		end
		return r;
	endfunction : pick_src

	logic [7:0] ctrl_ff;
	logic load_armed_ff, load_on_trig_en_ff, trig_seen_ff;
	logic [1:0] load_trig_sel_ff, offset_run_mode_ff, offset_trig_sel_ff;
	logic offset_match_point_ff;
	logic [7:0] phh_ff, phl_ff, dch_ff, dcl_ff, prh_ff, prl_ff, ofh_ff, ofl_ff;
	logic [3:0] match_d_ff, flags_ff;
	logic run_ff;
	logic aw_ok_ff, w_ok_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;

	// Write fires once both address and data are held
	logic wr_go, rd_go;
	logic [7:0] wbyte;
	logic ld_trig, ofs_trig, reload_now;
	assign wr_go = aw_ok_ff && w_ok_ff && !BVALID_O;
	assign rd_go = ARVALID_I && ARREADY_O;
	assign wbyte = w_strb_ff[0] ? w_data_ff[7:0] : 8'h00;
	assign ld_trig = pick_src(load_trig_sel_ff, RELOAD_TRIGGER_I);
	assign ofs_trig = pick_src(offset_trig_sel_ff, OFFSET_MATCH_SIG_I);
	assign reload_now = load_armed_ff && PERIOD_BOUNDARY_I &&
		(!load_on_trig_en_ff || trig_seen_ff || ld_trig);

	function automatic logic hit(input logic [7:0] off);
		return wr_go && w_strb_ff[0] && aw_addr_ff == off;
	endfunction : hit

	// AXI write channel capture, either order
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			AWREADY_O <= 1'b0;
			WREADY_O <= 1'b0;
			BVALID_O <= 1'b0;
			BRESP_O <= RESP_OKAY;
		end else begin
			AWREADY_O <= !aw_ok_ff && !AWREADY_O && AWVALID_I;
			WREADY_O <= !w_ok_ff && !WREADY_O && WVALID_I;
			if (AWVALID_I && AWREADY_O) begin
				aw_ok_ff <= 1'b1;
				aw_addr_ff <= {AWADDR_I[7:2], 2'b00};
			end
			if (WVALID_I && WREADY_O) begin
				w_ok_ff <= 1'b1;
				w_data_ff <= WDATA_I;
				w_strb_ff <= WSTRB_I;
			end
			if (wr_go) begin
				aw_ok_ff <= 1'b0;
				w_ok_ff <= 1'b0;
				BVALID_O <= 1'b1;
				BRESP_O <= (aw_addr_ff <= OFF_FLAGS) ? RESP_OKAY : RESP_SLVERR;
			end else if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end
	end

	// Control and trigger registers; unimplemented bits are never stored
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_ff <= RST_BYTE;
			load_on_trig_en_ff <= 1'b0;
			load_trig_sel_ff <= 2'h0;
			offset_run_mode_ff <= OFM_INDEP;
			offset_match_point_ff <= 1'b0;
			offset_trig_sel_ff <= 2'h0;
		end else begin
			ctrl_ff[CTRL_OUT_BIT] <= OUTPUT_STATE_I; // Core owns the output state
			if (hit(OFF_CTRL)) begin
				ctrl_ff[7:6] <= wbyte[7:6];
				ctrl_ff[4:2] <= wbyte[4:2];
			end
			if (hit(OFF_ENMIR)) begin
				ctrl_ff[CTRL_EN_BIT] <= wbyte[CHAN_ID - 2'h1];
			end
			if (hit(OFF_RELOAD)) begin
				load_on_trig_en_ff <= wbyte[LD_TRIG_EN_BIT];
				load_trig_sel_ff <= wbyte[1:0];
			end
			if (hit(OFF_OFSCTL)) begin
				offset_run_mode_ff <= wbyte[6:5];
				offset_match_point_ff <= wbyte[OFS_MATCH_PT_BIT];
				offset_trig_sel_ff <= wbyte[1:0];
			end
		end
	end

	// Load-armed flag; software arming wins over a same-cycle reload clear
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			load_armed_ff <= 1'b0;
			trig_seen_ff <= 1'b0;
		end else begin
			if (hit(OFF_RELOAD)) begin
				load_armed_ff <= wbyte[LD_ARMED_BIT];
			end else if (hit(OFF_LDMIR)) begin
				load_armed_ff <= wbyte[CHAN_ID - 2'h1];
			end else if (reload_now) begin
				load_armed_ff <= 1'b0;
			end
			if (reload_now || !load_armed_ff) begin
				trig_seen_ff <= 1'b0;
			end else if (ld_trig && load_on_trig_en_ff) begin
				trig_seen_ff <= 1'b1;
			end
		end
	end

	// Byte-wide value registers; software should fill both halves before arming
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			{phh_ff, phl_ff, dch_ff, dcl_ff} <= {4{RST_BYTE}};
			{prh_ff, prl_ff, ofh_ff, ofl_ff} <= {4{RST_BYTE}};
		end else begin
			if (hit(OFF_PHH)) phh_ff <= wbyte;
			if (hit(OFF_PHL)) phl_ff <= wbyte;
			if (hit(OFF_DCH)) dch_ff <= wbyte;
			if (hit(OFF_DCL)) dcl_ff <= wbyte;
			if (hit(OFF_PRH)) prh_ff <= wbyte;
			if (hit(OFF_PRL)) prl_ff <= wbyte;
			if (hit(OFF_OFH)) ofh_ff <= wbyte;
			if (hit(OFF_OFL)) ofl_ff <= wbyte;
		end
	end

	// Active buffers load only at a boundary, so a half-written pair is never seen
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PHASE_VALUE_O <= RST_VALUE;
			DUTY_VALUE_O <= RST_VALUE;
			PERIOD_VALUE_O <= RST_VALUE;
			OFFSET_VALUE_O <= RST_VALUE;
			RELOAD_O <= 1'b0;
		end else begin
			RELOAD_O <= reload_now;
			if (reload_now) begin
				PHASE_VALUE_O <= {phh_ff, phl_ff};
				DUTY_VALUE_O <= {dch_ff, dcl_ff};
				PERIOD_VALUE_O <= {prh_ff, prl_ff};
				OFFSET_VALUE_O <= {ofh_ff, ofl_ff};
			end
		end
	end

	// Offset-trigger slave run control
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			run_ff <= 1'b0;
			COUNTER_RESET_O <= 1'b0;
		end else begin
			COUNTER_RESET_O <= 1'b0;
			unique case (offset_run_mode_ff)
				OFM_INDEP: begin
					run_ff <= ctrl_ff[CTRL_EN_BIT];
				end
				OFM_START: begin
					if (ofs_trig) run_ff <= 1'b1;
					if (ofs_trig && !run_ff) COUNTER_RESET_O <= 1'b1;
				end
				OFM_ONESHOT: begin
					if (ofs_trig) begin
						run_ff <= 1'b1;
						COUNTER_RESET_O <= 1'b1;
					end else if (run_ff && PERIOD_BOUNDARY_I) begin
						run_ff <= 1'b0;
					end
				end
				OFM_CONT: begin
					if (ofs_trig) begin
						run_ff <= 1'b1;
						COUNTER_RESET_O <= 1'b1;
					end
				end
			endcase
			// A new offset setting makes a slave wait for its next synchronised start
			if (hit(OFF_OFSCTL)) run_ff <= 1'b0;
			if (!ctrl_ff[CTRL_EN_BIT]) run_ff <= 1'b0;
		end
	end

	// Offset match point and match edge flags
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			OFFSET_MATCH_SIG_O <= 1'b0;
			match_d_ff <= 4'h0;
			flags_ff <= 4'h0;
		end else begin
			if (ctrl_ff[3:2] == MODE_CENTER) begin
				OFFSET_MATCH_SIG_O <= OFFSET_EQ_I && (COUNT_UP_I != offset_match_point_ff);
			end else begin
				OFFSET_MATCH_SIG_O <= OFFSET_EQ_I;
			end
			match_d_ff <= MATCH_I;
			// Rising edges set; a clear in the same cycle loses to a new edge
			flags_ff <= (hit(OFF_FLAGS) ? flags_ff & ~wbyte[3:0] : flags_ff)
				| (MATCH_I & ~match_d_ff);
		end
	end

	// Mirror writes forwarded to the siblings as one-cycle pulses
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SIB_ENABLE_WR_O <= 3'h0;
			SIB_ENABLE_VAL_O <= 3'h0;
			SIB_ARMED_WR_O <= 3'h0;
			SIB_ARMED_VAL_O <= 3'h0;
			ENABLE_O <= 1'b0;
			MODE_O <= 2'h0;
			RUN_O <= 1'b0;
		end else begin
			SIB_ENABLE_WR_O <= {3{hit(OFF_ENMIR)}};
			SIB_ENABLE_VAL_O <= wbyte[2:0];
			SIB_ARMED_WR_O <= {3{hit(OFF_LDMIR)}};
			SIB_ARMED_VAL_O <= wbyte[2:0];
			ENABLE_O <= ctrl_ff[CTRL_EN_BIT];
			MODE_O <= ctrl_ff[3:2];
			RUN_O <= run_ff;
		end
	end

	// Mirror views: own bit from local state, others from siblings
	logic [2:0] en_view, ld_view, out_view;
	always_comb begin
		en_view = SIB_ENABLE_I;
		ld_view = SIB_ARMED_I;
		out_view = SIB_OUTPUT_I;
		en_view[CHAN_ID - 2'h1] = ctrl_ff[CTRL_EN_BIT];
		ld_view[CHAN_ID - 2'h1] = load_armed_ff;
		out_view[CHAN_ID - 2'h1] = ctrl_ff[CTRL_OUT_BIT];
	end

	// Read data mux; reserved bits read as zero
	logic [7:0] rbyte;
	logic rmapped;
	always_comb begin
		rbyte = 8'h00;
		rmapped = 1'b1;
		unique case ({ARADDR_I[7:2], 2'b00})
			OFF_CTRL: rbyte = ctrl_ff;
			OFF_RELOAD: rbyte = {load_armed_ff, load_on_trig_en_ff, 4'h0, load_trig_sel_ff};
			OFF_OFSCTL: rbyte = {1'b0, offset_run_mode_ff, offset_match_point_ff, 2'h0,
				offset_trig_sel_ff};
			OFF_ENMIR: rbyte = {5'h00, en_view};
			OFF_LDMIR: rbyte = {5'h00, ld_view};
			OFF_OUTMIR: rbyte = {5'h00, out_view};
			OFF_PHH: rbyte = phh_ff;
			OFF_PHL: rbyte = phl_ff;
			OFF_DCH: rbyte = dch_ff;
			OFF_DCL: rbyte = dcl_ff;
			OFF_PRH: rbyte = prh_ff;
			OFF_PRL: rbyte = prl_ff;
			OFF_OFH: rbyte = ofh_ff;
			OFF_OFL: rbyte = ofl_ff;
			OFF_FLAGS: rbyte = {4'h0, flags_ff};
			default: rmapped = 1'b0;
		endcase
	end

	// AXI read channel: one outstanding read
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0000_0000;
			RRESP_O <= RESP_OKAY;
		end else begin
			ARREADY_O <= ARVALID_I && !ARREADY_O && !RVALID_O;
			if (rd_go) begin
				RVALID_O <= 1'b1;
				RDATA_O <= {24'h000000, rbyte};
				RRESP_O <= rmapped ? RESP_OKAY : RESP_SLVERR;
			end else if (RVALID_O && RREADY_I) begin
				RVALID_O <= 1'b0;
			end
		end
	end

endmodule : pwm_chan_regs

// *** hdl/pwm_regs_pkg.sv ***
// Package for the PWM channel trigger and value register block.
// Assumes an AXI4-Lite master with 32-bit data; one register per aligned word.
package pwm_regs_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_OFSCTL = 8'h08;
	localparam logic [7:0] OFF_ENMIR = 8'h0C;
	localparam logic [7:0] OFF_LDMIR = 8'h10;
	localparam logic [7:0] OFF_OUTMIR = 8'h14;
	localparam logic [7:0] OFF_PHH = 8'h18;
	localparam logic [7:0] OFF_PHL = 8'h1C;
	localparam logic [7:0] OFF_DCH = 8'h20;
	localparam logic [7:0] OFF_DCL = 8'h24;
	localparam logic [7:0] OFF_PRH = 8'h28;
	localparam logic [7:0] OFF_PRL = 8'h2C;
	localparam logic [7:0] OFF_OFH = 8'h30;
	localparam logic [7:0] OFF_OFL = 8'h34;
	localparam logic [7:0] OFF_FLAGS = 8'h38;
	// Field positions
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int LD_ARMED_BIT = 7;
	localparam int LD_TRIG_EN_BIT = 6;
	localparam int OFS_MATCH_PT_BIT = 4;
	// Codes
	localparam logic [1:0] MODE_CENTER = 2'h3;
	localparam logic [1:0] OFM_INDEP = 2'h0;
	localparam logic [1:0] OFM_START = 2'h1;
	localparam logic [1:0] OFM_ONESHOT = 2'h2;
	localparam logic [1:0] OFM_CONT = 2'h3;
	localparam logic [1:0] SEL_RESERVED = 2'h0;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_VALUE = 16'h0000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwm_regs_pkg

// *** test/pwm_chan_regs_sva.sv ***
// Checker: bus answers, reload timing and pulse shapes of one PWM channel.
// Assumes a single clock domain; bound to every register block instance.
`timescale 1ns/10ps
module pwm_chan_regs_sva
	import pwm_regs_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	// Bus
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic WVALID_I,
	// Links and core
	input wire logic PERIOD_BOUNDARY_I,
	input wire logic [3:1] OFFSET_MATCH_SIG_I,
	input wire logic [3:1] SIB_ENABLE_WR_O,
	input wire logic [3:1] SIB_ARMED_WR_O,
	input wire logic RELOAD_O,
	input wire logic COUNTER_RESET_O,
	input wire logic [15:0] PHASE_VALUE_O,
	input wire logic [15:0] DUTY_VALUE_O,
	input wire logic [15:0] PERIOD_VALUE_O,
	input wire logic [15:0] OFFSET_VALUE_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// No write can re-arm the flag while the write channel stays quiet
	sequence quiet_after_reload;
		(RELOAD_O && !WVALID_I) ##1 !WVALID_I [*6];
	endsequence
	sequence boundary_seen;
		$past(PERIOD_BOUNDARY_I) || $past(PERIOD_BOUNDARY_I, 2);
	endsequence
	a_reload_once: assert property (quiet_after_reload |-> !RELOAD_O)
		else $error("reload repeated without re-arming");
	a_reload_at_bound: assert property (RELOAD_O |-> boundary_seen)
		else $error("reload away from a period boundary");
	a_value_at_bound: assert property ($changed({PHASE_VALUE_O, DUTY_VALUE_O,
		PERIOD_VALUE_O, OFFSET_VALUE_O}) |-> boundary_seen)
		else $error("active buffer changed away from a boundary");
	a_reset_on_trig: assert property (COUNTER_RESET_O |->
		$past(OFFSET_MATCH_SIG_I) != 0 || $past(OFFSET_MATCH_SIG_I, 2) != 0)
		else $error("counter reset without an offset trigger");
	a_reset_one_cycle: assert property (COUNTER_RESET_O |=> !COUNTER_RESET_O)
		else $error("counter reset longer than one cycle");
	a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read answer late");
	a_read_single: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
		else $error("read answer repeated");
	a_enable_pulse: assert property (SIB_ENABLE_WR_O != 0 |=> SIB_ENABLE_WR_O == 0)
		else $error("enable mirror pulse too long");
	a_armed_pulse: assert property (SIB_ARMED_WR_O != 0 |=> SIB_ARMED_WR_O == 0)
		else $error("armed mirror pulse too long");
endmodule : pwm_chan_regs_sva
bind pwm_chan_regs pwm_chan_regs_sva pwm_chan_regs_sva_i (.*);

// *** test/pwm_sibling_model.sv ***
// Sibling channels 2 and 3: pulse sources and mirror bit holders.
// Assumes the block under test is channel 1; its own link index is ignored.
`timescale 1ns/10ps
module pwm_sibling_model (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	// Mirror writes from the block
	input wire logic [3:1] SIB_ENABLE_WR_O,
	input wire logic [3:1] SIB_ENABLE_VAL_O,
	input wire logic [3:1] SIB_ARMED_WR_O,
	input wire logic [3:1] SIB_ARMED_VAL_O,
	// Pulse requests from the bench
	input wire logic [3:1] lt_req,
	input wire logic [3:1] om_req,
	// Links to the block
	output logic [3:1] RELOAD_TRIGGER_I,
	output logic [3:1] OFFSET_MATCH_SIG_I,
	output logic [3:1] SIB_ENABLE_I,
	output logic [3:1] SIB_ARMED_I,
	output logic [3:1] SIB_OUTPUT_I
);
	logic [3:1] en_ff;
	logic [3:1] ar_ff;
	// Mirror writes land only on bits that were pulsed
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			en_ff <= 3'h0;
			ar_ff <= 3'h0;
		end else begin
			en_ff <= (en_ff & ~SIB_ENABLE_WR_O) | (SIB_ENABLE_VAL_O & SIB_ENABLE_WR_O);
			ar_ff <= (ar_ff & ~SIB_ARMED_WR_O) | (SIB_ARMED_VAL_O & SIB_ARMED_WR_O);
		end
	end
	// One-cycle trigger pulses, launched off the clock edge
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RELOAD_TRIGGER_I <= 3'h0;
			OFFSET_MATCH_SIG_I <= 3'h0;
		end else begin
			RELOAD_TRIGGER_I <= lt_req;
			OFFSET_MATCH_SIG_I <= om_req;
		end
	end
	// Own index held high so that a block reading it would show up
	assign SIB_ENABLE_I = {en_ff[3:2], 1'b1};
	assign SIB_ARMED_I = {ar_ff[3:2], 1'b1};
	assign SIB_OUTPUT_I = 3'h5;
endmodule : pwm_sibling_model

// *** test/test_pwm16_trigger_and_value_regs.sv ***
// Bench for the PWM channel register block, channel 1, with two siblings.
// Assumes an AXI4-Lite slave that answers every request; only the watchdog ends a wait.
`timescale 1ns/10ps
module test_pwm16_trigger_and_value_regs
	import pwm_regs_pkg::*;
;
	logic CORE_CLK_I = 0, ARST_N_I = 0, AWVALID_I = 0, WVALID_I = 0, ARVALID_I = 0;
	logic BREADY_I = 1, RREADY_I = 1, PERIOD_BOUNDARY_I = 0, OUTPUT_STATE_I = 0;
	logic COUNT_UP_I = 0, OFFSET_EQ_I = 0, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O;
	logic RVALID_O, ENABLE_O, RELOAD_O, COUNTER_RESET_O, RUN_O, OFFSET_MATCH_SIG_O;
	logic [7:0] AWADDR_I = 8'h00, ARADDR_I = 8'h00;
	logic [31:0] WDATA_I = 32'h0, RDATA_O;
	logic [3:0] WSTRB_I = 4'hF, MATCH_I = 4'h0;
	logic [1:0] BRESP_O, RRESP_O, MODE_O;
	logic [3:1] RELOAD_TRIGGER_I, OFFSET_MATCH_SIG_I, SIB_ENABLE_I, SIB_ARMED_I, SIB_OUTPUT_I;
	logic [3:1] SIB_ENABLE_WR_O, SIB_ENABLE_VAL_O, SIB_ARMED_WR_O, SIB_ARMED_VAL_O;
	logic [3:1] lt_req = 3'h0, om_req = 3'h0;
	logic [15:0] PHASE_VALUE_O, DUTY_VALUE_O, PERIOD_VALUE_O, OFFSET_VALUE_O;
	logic [7:0] ra[9] = '{OFF_RELOAD, OFF_OFSCTL, OFF_PHH, OFF_PHL, OFF_DCH, OFF_DCL,
		OFF_PRH, OFF_PRL, OFF_OFH};
	logic [7:0] rm[9] = '{8'hC3, 8'h73, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0] oc[6] = '{8'h02, 8'h22, 8'h42, 8'h63, 8'h61, 8'h60};
	logic [3:1] ot[6] = '{3'h2, 3'h2, 3'h2, 3'h4, 3'h1, 3'h7};
	int ox[6] = '{0, 1, 2, 2, 0, 0};
	// Expected slave run level after each offset case, bit i for case i
	logic [5:0] orun = 6'h0F;
	int mismatches = 0, comparisons = 0, cr_cnt = 0, c0;
	logic [7:0] p;
	pwm_chan_regs pwm_chan_regs_i (.*);
	pwm_sibling_model pwm_sibling_model_i (.*);
	// 25 MHz clock
	initial begin
		forever #20 CORE_CLK_I = ~CORE_CLK_I;
	end
	// Counter reset pulses, counted at the edge that sees them
	always @(posedge CORE_CLK_I) begin
		if (COUNTER_RESET_O === 1'b1) cr_cnt++;
	end
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h want %h", $time, m, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		AWADDR_I <= a;
		WDATA_I <= {24'h0, d};
		AWVALID_I <= 1;
		WVALID_I <= 1;
		// Each channel released at its own handshake; no cycle count is assumed
		do begin
			@(posedge CORE_CLK_I);
			if (AWREADY_O) AWVALID_I <= 0;
			if (WREADY_O) WVALID_I <= 0;
		end while (BVALID_O !== 1'b1);
		chk(BRESP_O, a > OFF_FLAGS ? RESP_SLVERR : RESP_OKAY, "write resp");
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		ARADDR_I <= a;
		ARVALID_I <= 1;
		do begin
			@(posedge CORE_CLK_I);
			if (ARREADY_O) ARVALID_I <= 0;
		end while (RVALID_O !== 1'b1);
		chk(RDATA_O, {24'h0, e}, "read data");
		chk(RRESP_O, a > OFF_FLAGS ? RESP_SLVERR : RESP_OKAY, "read resp");
	endtask : rd
	// Boundary and trigger pulses, each followed by settling cycles
	task bnd();
		PERIOD_BOUNDARY_I <= 1;
		@(posedge CORE_CLK_I);
		PERIOD_BOUNDARY_I <= 0;
		repeat (3) @(posedge CORE_CLK_I);
	endtask : bnd
	task trg(input logic [3:1] l, input logic [3:1] o);
		lt_req <= l;
		om_req <= o;
		@(posedge CORE_CLK_I);
		lt_req <= 3'h0;
		om_req <= 3'h0;
		repeat (4) @(posedge CORE_CLK_I);
	endtask : trg
	task test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge CORE_CLK_I);
		mismatches++;
		test_done();
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge CORE_CLK_I);
		ARST_N_I <= 1;
		@(posedge CORE_CLK_I);
		rd(OFF_ENMIR, 8'h00);
		rd(OFF_LDMIR, 8'h00);
		for (int i = 0; i < 9; i++) begin
			rd(ra[i], 8'h00);
			wr(ra[i], 8'h5A);
			rd(ra[i], 8'h5A & rm[i]);
		end
		wr(8'h3C, 8'h5A);
		rd(8'h3C, 8'h00);
		$display("test registers done");
		wr(OFF_PHH, 8'h12);
		wr(OFF_PHL, 8'h34);
		bnd();
		chk(PHASE_VALUE_O, 16'h0000, "unarmed load");
		wr(OFF_RELOAD, 8'h80);
		wr(OFF_RELOAD, 8'h00);
		bnd();
		chk(PHASE_VALUE_O, 16'h0000, "cancelled load");
		wr(OFF_RELOAD, 8'h80);
		bnd();
		chk(PHASE_VALUE_O, 16'h1234, "armed load");
		rd(OFF_RELOAD, 8'h00);
		p = 8'h34;
		for (int s = 0; s < 4; s++) begin
			wr(OFF_PHL, 8'(s));
			wr(OFF_RELOAD, 8'hC0 | 8'(s));
			bnd();
			chk(PHASE_VALUE_O, {8'h12, p}, "load waits for trigger");
			trg(s == 0 ? 3'h7 : 3'(1 << (s - 1)), 3'h0);
			bnd();
			if (s > 1) p = 8'(s);
			chk(PHASE_VALUE_O, {8'h12, p}, "triggered load");
			wr(OFF_RELOAD, 8'h00);
		end
		$display("test reload done");
		// The channel is enabled first, so that a started slave keeps running
		wr(OFF_ENMIR, 8'h01);
		rd(OFF_ENMIR, 8'h01);
		chk(ENABLE_O, 1'b1, "enable mirror set");
		for (int i = 0; i < 6; i++) begin
			wr(OFF_OFSCTL, oc[i]);
			c0 = cr_cnt;
			trg(3'h0, ot[i]);
			trg(3'h0, ot[i]);
			chk(cr_cnt - c0, ox[i], "offset mode");
			chk(RUN_O, orun[i], "slave run");
		end
		$display("test offset done");
		wr(OFF_ENMIR, 8'hFE);
		rd(OFF_ENMIR, 8'h06);
		chk(ENABLE_O, 1'b0, "enable mirror own bit");
		wr(OFF_LDMIR, 8'h07);
		rd(OFF_LDMIR, 8'h07);
		rd(OFF_RELOAD, 8'h80);
		wr(OFF_LDMIR, 8'h00);
		rd(OFF_LDMIR, 8'h00);
		rd(OFF_OUTMIR, 8'h04);
		OUTPUT_STATE_I <= 1;
		rd(OFF_OUTMIR, 8'h05);
		$display("test mirrors done");
		wr(OFF_CTRL, 8'h8C);
		wr(OFF_OFSCTL, 8'h10);
		chk(MODE_O, MODE_CENTER, "centre mode");
		OFFSET_EQ_I <= 1;
		repeat (3) @(posedge CORE_CLK_I);
		chk(OFFSET_MATCH_SIG_O, 1'b1, "centre down match");
		COUNT_UP_I <= 1;
		repeat (3) @(posedge CORE_CLK_I);
		chk(OFFSET_MATCH_SIG_O, 1'b0, "centre up match");
		wr(OFF_CTRL, 8'h80);
		repeat (3) @(posedge CORE_CLK_I);
		chk(OFFSET_MATCH_SIG_O, 1'b1, "match point ignored");
		OFFSET_EQ_I <= 0;
		MATCH_I <= 4'h5;
		repeat (3) @(posedge CORE_CLK_I);
		rd(OFF_FLAGS, 8'h05);
		wr(OFF_FLAGS, 8'h0F);
		rd(OFF_FLAGS, 8'h00);
		$display("test match done");
		test_done();
	end
endmodule : test_pwm16_trigger_and_value_regs
